// File: hdl/xcc_ctrl.sv
// control and status of an execute-in-place flash cache: tag memory,
// flush engine, alias policy, counters, stream fifo and register port
// assumes one 100 MHz clock and a register master that strobes for one cycle
//
// Contract
// - power-down bit powers cache memories down, contents kept, no access
// - writing one to power-down clears the cache enable bit
// - cache-as-sram access while powered down gets a bus error
// - bad-write bit set faults writes to non-zero aliases, else drops them
// - write to alias zero invalidates a tag match regardless of bad-write bit
// - cache disabled sends every xip access straight to flash, no lookup; here alias-zero writes still look up and invalidate a tag match
// - cache enabled, cacheable access skips flash on valid tag match
// - cache enabled, cache-as-sram access leaves data alone and errors
// - flush trigger clears all tags, data memory untouched
// - reading the flush register stalls until any flush finishes
// - flush-ready status reads zero during flush, one otherwise
// - a flush starts on leaving reset and on software request
// - two-entry stream fifo; status bit two full, bit one empty
// - access counter counts every xip access through any alias
// - hit counter counts only accesses served from cached data
// - registers decoded at word offsets 0x00 to 0x24 of the block base
// - counters are 32 bits, saturate, clear on any write
// - flush walks the tags one per cycle; xip masters stall meanwhile
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "xcc_defs.svh"
module xcc_ctrl
  import xcc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // register port
  input wire logic [31:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic REG_WAIT,
  // execute-in-place requests
  input wire xcc_xip_req_t XIP_REQ,
  output logic XIP_STALL,
  output xcc_xip_rsp_t XIP_RSP,
  // line fill from the flash side
  input wire logic FILL_STB,
  input wire logic [`XCC_ADDR_W-1:0] FILL_ADDR,
  // cache-as-sram requests
  input wire logic SRAM_REQ,
  output logic SRAM_DONE,
  output logic SRAM_ERR,
  // stream fifo filling side
  input wire logic STREAM_PUSH,
  input wire logic [31:0] STREAM_DATA,
  output logic STREAM_READY,
  output logic [29:0] STREAM_ADDR,
  output logic [`XCC_SCNT_W-1:0] STREAM_COUNT,
  // memory power and interrupt
  output logic CACHE_PD,
  output logic CACHE_EN,
  output logic IRQ
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    sat_inc = (v == `XCC_CNT_MAX) ? v : v + 32'h1;
  endfunction

  function automatic logic [`XCC_IDX_W-1:0] line_idx(
    input logic [`XCC_ADDR_W-1:0] a);
    line_idx = a[`XCC_IDX_LSB +: `XCC_IDX_W];
  endfunction

  function automatic logic [`XCC_TAG_W-1:0] line_tag(
    input logic [`XCC_ADDR_W-1:0] a);
    line_tag = a[`XCC_TAG_LSB +: `XCC_TAG_W];
  endfunction

  function automatic logic reg_hit(input logic [31:0] a,
                                   input logic [7:0] off);
    reg_hit = (a[31:8] == 24'(`XCC_BASE >> 8)) && (a[7:0] == off);
  endfunction

  // a write strobe aimed at one register; the upper address bits must
  // match the block base too, so aliases above the map stay silent
  function automatic logic reg_wr_hit(input logic [31:0] a,
                                      input logic wr,
                                      input logic [7:0] off);
    reg_wr_hit = wr && reg_hit(a, off);
  endfunction

  // ------------------------------------------------------------
  // alias decodes
  // ------------------------------------------------------------
  // only the two cacheable aliases may ever be served from the tags
  function automatic logic is_cacheable(input xcc_alias_t s);
    is_cacheable = (s == XCC_ALIAS_CACHE_ALLOC) ||
                   (s == XCC_ALIAS_CACHE_NOALLOC);
  endfunction

  // a miss through an allocating alias asks the flash side for a fill
  function automatic logic allocates(input xcc_alias_t s);
    allocates = (s == XCC_ALIAS_CACHE_ALLOC) ||
                (s == XCC_ALIAS_BYPASS_ALLOC);
  endfunction

  // ------------------------------------------------------------
  // tag memory
  // ------------------------------------------------------------
  // the tags are a plain array, kept out of the state struct; the flush walk
  // and invalidates clear them, and reset starts a walk, so no reset is needed on the array
  xcc_tag_t tag_mem [0:(1 << `XCC_IDX_W)-1];
  logic tag_we;
  logic [`XCC_IDX_W-1:0] tag_widx;
  xcc_tag_t tag_wdata;
  xcc_tag_t look;

  always_ff @(posedge CLK) begin
    if (tag_we) begin
      tag_mem[tag_widx] <= tag_wdata;
    end
  end

  assign look = tag_mem[line_idx(XIP_REQ.addr)];

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  xcc_state_reg_t r;
  xcc_state_reg_t next_r;

  logic flushing;
  logic xip_acc;
  logic tag_match;
  logic cacheable;
  logic is_hit;
  logic wr_ctrl;
  logic wr_flush;
  logic rd_pop;
  logic [31:0] rd_val;
  logic [2:0] irq_set;
  logic pop_ok;
  logic push_ok;
  logic wr_hit;
  logic wr_acc;
  logic wr_saddr;
  logic wr_scnt;
  logic wr_istat;
  logic wr_imask;
  logic inval;
  logic bad_wr;

  assign flushing = (r.state == XCC_ST_FLUSH);
  assign XIP_STALL = flushing;
  assign xip_acc = XIP_REQ.valid && !flushing;
  assign tag_match = look.valid && (look.tag == line_tag(XIP_REQ.addr));
  assign cacheable = is_cacheable(XIP_REQ.alias_sel);
  assign is_hit = r.en && cacheable && tag_match && !XIP_REQ.write;
  assign wr_ctrl = REG_WR && reg_hit(REG_ADDR, `XCC_OFF_CTRL);
  assign wr_flush = REG_WR && reg_hit(REG_ADDR, `XCC_OFF_FLUSH) &&
                    REG_WDATA[0];
  assign rd_pop = REG_RD && reg_hit(REG_ADDR, `XCC_OFF_SPOP);
  assign pop_ok = rd_pop && (r.fifo_lvl != 2'h0);
  assign STREAM_READY = (r.fifo_lvl != 2'(`XCC_FIFO_DEPTH));
  assign push_ok = STREAM_PUSH && STREAM_READY;
  assign REG_WAIT = r.flush_rd_pend;

  // ------------------------------------------------------------
  // register write and xip write decodes
  // ------------------------------------------------------------
  assign wr_hit = reg_wr_hit(REG_ADDR, REG_WR, `XCC_OFF_HIT);
  assign wr_acc = reg_wr_hit(REG_ADDR, REG_WR, `XCC_OFF_ACC);
  assign wr_saddr = reg_wr_hit(REG_ADDR, REG_WR, `XCC_OFF_SADDR);
  assign wr_scnt = reg_wr_hit(REG_ADDR, REG_WR, `XCC_OFF_SCNT);
  assign wr_istat = reg_wr_hit(REG_ADDR, REG_WR, `XCC_OFF_IRQ_STAT);
  assign wr_imask = reg_wr_hit(REG_ADDR, REG_WR, `XCC_OFF_IRQ_MASK);
  // invalidating is a tag write, so it is skipped while powered down
  assign inval = xip_acc && XIP_REQ.write &&
                 XIP_REQ.alias_sel == XCC_ALIAS_CACHE_ALLOC &&
                 !r.pd && tag_match;
  // non-zero alias writes never touch the tags, faulted or not
  assign bad_wr = xip_acc && XIP_REQ.write &&
                  XIP_REQ.alias_sel != XCC_ALIAS_CACHE_ALLOC;

  // ------------------------------------------------------------
  // tag write port: flush walk, then invalidate, then fill
  // ------------------------------------------------------------
  always_comb begin
    tag_we = 1'b0;
    tag_widx = line_idx(FILL_ADDR);
    tag_wdata = '0;
    if (flushing) begin
      tag_we = 1'b1;
      tag_widx = r.flush_idx;
    end else if (inval) begin
      tag_we = 1'b1;
      tag_widx = line_idx(XIP_REQ.addr);
    end else if (FILL_STB && r.en) begin
      tag_we = 1'b1;
      tag_wdata.valid = 1'b1;
      tag_wdata.tag = line_tag(FILL_ADDR);
    end
  end

  // ------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------
  always_comb begin
    // unmapped offsets and reserved bits fall through to zero
    rd_val = 32'h0;
    case (1'b1)
      reg_hit(REG_ADDR, `XCC_OFF_CTRL): begin
        rd_val[`XCC_CTRL_EN] = r.en;
        rd_val[`XCC_CTRL_BADWR] = r.badwr;
        rd_val[`XCC_CTRL_PD] = r.pd;
      end
      reg_hit(REG_ADDR, `XCC_OFF_STAT): begin
        rd_val[`XCC_STAT_READY] = !flushing;
        rd_val[`XCC_STAT_EMPTY] = (r.fifo_lvl == 2'h0);
        rd_val[`XCC_STAT_FULL] = (r.fifo_lvl == 2'(`XCC_FIFO_DEPTH));
      end
      reg_hit(REG_ADDR, `XCC_OFF_HIT): rd_val = r.hit_cnt;
      reg_hit(REG_ADDR, `XCC_OFF_ACC): rd_val = r.acc_cnt;
      reg_hit(REG_ADDR, `XCC_OFF_SADDR): rd_val = {r.saddr, 2'h0};
      reg_hit(REG_ADDR, `XCC_OFF_SCNT): rd_val = 32'(r.scnt);
      reg_hit(REG_ADDR, `XCC_OFF_SPOP): rd_val = r.fifo[0];
      reg_hit(REG_ADDR, `XCC_OFF_IRQ_STAT): rd_val = 32'(r.irq_stat);
      reg_hit(REG_ADDR, `XCC_OFF_IRQ_MASK): rd_val = 32'(r.irq_mask);
      default: rd_val = 32'h0;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;
    irq_set = 3'h0;
    next_r.rsp = '0;
    next_r.sram_done = 1'b0;
    next_r.sram_err = 1'b0;

    // flush engine
    case (r.state)
      XCC_ST_FLUSH: begin
        next_r.flush_idx = r.flush_idx + 11'h1;
        if (r.flush_idx == `XCC_LAST_IDX) begin
          next_r.state = XCC_ST_IDLE;
          irq_set[`XCC_IRQ_FLUSHED] = 1'b1;
        end
      end
      XCC_ST_IDLE: next_r.flush_idx = '0;
      default: next_r.state = XCC_ST_FLUSH;
    endcase
    // a new request restarts the walk from entry zero
    if (wr_flush) begin
      next_r.state = XCC_ST_FLUSH;
      next_r.flush_idx = '0;
    end

    // control register
    if (wr_ctrl) begin
      next_r.badwr = REG_WDATA[`XCC_CTRL_BADWR];
      next_r.pd = REG_WDATA[`XCC_CTRL_PD];
      next_r.en = REG_WDATA[`XCC_CTRL_EN] &&
                  !REG_WDATA[`XCC_CTRL_PD];
    end

    // execute-in-place access
    if (xip_acc) begin
      next_r.acc_cnt = sat_inc(r.acc_cnt);
      next_r.rsp.done = 1'b1;
      if (XIP_REQ.write) begin
        if (bad_wr && r.badwr) begin
          next_r.rsp.err = 1'b1;
          irq_set[`XCC_IRQ_BADWR] = 1'b1;
        end
      end else if (is_hit) begin
        next_r.rsp.hit = 1'b1;
        next_r.hit_cnt = sat_inc(r.hit_cnt);
      end else begin
        next_r.rsp.to_flash = 1'b1;
        next_r.rsp.alloc = r.en && allocates(XIP_REQ.alias_sel);
      end
    end

    // cache-as-sram access; the data array sits beside this block, so only
    // the answer and its error are made here
    if (SRAM_REQ) begin
      next_r.sram_done = 1'b1;
      if (r.pd || r.en) begin
        next_r.sram_err = 1'b1;
        irq_set[`XCC_IRQ_SRAMERR] = 1'b1;
      end
    end

    // counters clear on any written value
    if (wr_hit) begin
      next_r.hit_cnt = 32'h0;
    end
    if (wr_acc) begin
      next_r.acc_cnt = 32'h0;
    end

    // stream registers
    if (wr_saddr) begin
      next_r.saddr = REG_WDATA[31:2];
    end
    if (wr_scnt) begin
      next_r.scnt = REG_WDATA[`XCC_SCNT_W-1:0];
    end

    // stream fifo; a push into a full fifo is held off by STREAM_READY
    if (pop_ok) begin
      next_r.fifo[0] = r.fifo[1];
    end
    if (push_ok) begin
      next_r.fifo[(r.fifo_lvl - 2'(pop_ok)) == 2'h0 ? 0 : 1] = STREAM_DATA;
    end
    next_r.fifo_lvl = r.fifo_lvl + 2'(push_ok) - 2'(pop_ok);

    // interrupts: set wins over write-one-to-clear
    if (wr_istat) begin
      next_r.irq_stat = r.irq_stat & ~REG_WDATA[2:0];
    end
    next_r.irq_stat = next_r.irq_stat | irq_set;
    if (wr_imask) begin
      next_r.irq_mask = REG_WDATA[2:0];
    end

    // register read; a flush read during a flush is held until it ends
    if (r.flush_rd_pend) begin
      if (!flushing) begin
        next_r.flush_rd_pend = 1'b0;
        next_r.rdata = 32'h0;
      end
    end else if (REG_RD) begin
      next_r.rdata = rd_val;
      if (reg_hit(REG_ADDR, `XCC_OFF_FLUSH) && flushing) begin
        next_r.flush_rd_pend = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // state register; leaving reset lands in a flush walk
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      r <= '0;
      r.state <= XCC_ST_FLUSH;
      r.en <= `XCC_EN_RST;
      r.badwr <= `XCC_BADWR_RST;
      r.pd <= `XCC_PD_RST;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign REG_RDATA = r.rdata;
  assign XIP_RSP = r.rsp;
  assign SRAM_DONE = r.sram_done;
  assign SRAM_ERR = r.sram_err;
  assign STREAM_ADDR = r.saddr;
  assign STREAM_COUNT = r.scnt;
  assign CACHE_PD = r.pd;
  assign CACHE_EN = r.en;
  assign IRQ = |(r.irq_stat & r.irq_mask);

endmodule

// File: hdl/xcc_defs.svh
// offsets, field positions, reset values and counts of the xip cache control
// assumes inclusion by xcc_pkg.sv and xcc_ctrl.sv only
`ifndef XCC_DEFS_SVH
`define XCC_DEFS_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define XCC_BASE 32'h14000000
`define XCC_OFF_CTRL 8'h00
`define XCC_OFF_FLUSH 8'h04
`define XCC_OFF_STAT 8'h08
`define XCC_OFF_HIT 8'h0C
`define XCC_OFF_ACC 8'h10
`define XCC_OFF_SADDR 8'h14
`define XCC_OFF_SCNT 8'h18
`define XCC_OFF_SPOP 8'h1C
`define XCC_OFF_IRQ_STAT 8'h20
`define XCC_OFF_IRQ_MASK 8'h24

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define XCC_CTRL_EN 0
`define XCC_CTRL_BADWR 1
`define XCC_CTRL_PD 3
`define XCC_EN_RST 1'h1
`define XCC_BADWR_RST 1'h1
`define XCC_PD_RST 1'h0
`define XCC_STAT_READY 0
`define XCC_STAT_EMPTY 1
`define XCC_STAT_FULL 2
`define XCC_IRQ_FLUSHED 0
`define XCC_IRQ_BADWR 1
`define XCC_IRQ_SRAMERR 2
`define XCC_SCNT_W 22
`define XCC_FIFO_DEPTH 2

// ------------------------------------------------------------
// tag memory geometry; one entry per 8-byte line, 2048 entries
// ------------------------------------------------------------
`define XCC_IDX_W 11
`define XCC_TAG_W 10
`define XCC_ADDR_W 24
`define XCC_IDX_LSB 3
`define XCC_TAG_LSB 14
`define XCC_LAST_IDX 11'h7FF
`define XCC_CNT_MAX 32'hFFFFFFFF

`endif

// File: hdl/xcc_pkg.sv
// types of the xip cache control block
// assumes xcc_defs.svh is on the include path
package xcc_pkg;
  `include "xcc_defs.svh"

  typedef enum logic [1:0] {
    XCC_ALIAS_CACHE_ALLOC = 2'h0,
    XCC_ALIAS_CACHE_NOALLOC = 2'h1,
    XCC_ALIAS_BYPASS_ALLOC = 2'h2,
    XCC_ALIAS_BYPASS = 2'h3
  } xcc_alias_t;

  typedef enum logic [1:0] {
    XCC_ST_FLUSH = 2'h1,
    XCC_ST_IDLE = 2'h2
  } xcc_state_t;

  // one execute-in-place request from the system bus
  typedef struct packed {
    logic valid;
    logic write;
    xcc_alias_t alias_sel;
    logic [`XCC_ADDR_W-1:0] addr;
  } xcc_xip_req_t;

  // registered answer to an accepted request
  typedef struct packed {
    logic done;
    logic hit;
    logic to_flash;
    logic alloc;
    logic err;
  } xcc_xip_rsp_t;

  typedef struct packed {
    logic valid;
    logic [`XCC_TAG_W-1:0] tag;
  } xcc_tag_t;

  typedef struct packed {
    xcc_state_t state;
    logic [`XCC_IDX_W-1:0] flush_idx;
    logic en;
    logic badwr;
    logic pd;
    logic [31:0] hit_cnt;
    logic [31:0] acc_cnt;
    logic [29:0] saddr;
    logic [`XCC_SCNT_W-1:0] scnt;
    logic [1:0][31:0] fifo;
    logic [1:0] fifo_lvl;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [31:0] rdata;
    logic flush_rd_pend;
    xcc_xip_rsp_t rsp;
    logic sram_done;
    logic sram_err;
  } xcc_state_reg_t;
endpackage

// File: test/tb.sv
// self-checking bench of the xip cache control against a queue model
// assumes xcc_master on the request side and xcc_chk bound to the design
`timescale 1ns/1ps
module tb
  import xcc_pkg::*;
;
  localparam logic [31:0] BASE = 32'h14000000;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, fill = 1'b0;
  logic sreq = 1'b0, push = 1'b0, wt, stall, sdone, serr, srdy, pd, en, irq;
  logic [31:0] addr = '0, wdata = '0, sdat = '0, rdata, v, lf = 32'hDB44;
  logic [23:0] fad = '0, ad;
  logic [29:0] sad;
  logic [21:0] scn;
  logic m_en = 1'b1, m_bw = 1'b1, m_pd = 1'b0;
  xcc_xip_req_t req;
  xcc_xip_rsp_t rsp, r;
  int num_errors = 0, n_compared = 0, hits = 0, accs = 0, waited, cyc = 0;
  logic [9:0] tagv [int];
  logic [31:0] fq [$];
  always #5 clk = ~clk;
  xcc_ctrl dut_u (.CLK(clk), .NRST(nrst), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .REG_WAIT(wt), .XIP_REQ(req), .XIP_STALL(stall), .XIP_RSP(rsp),
    .FILL_STB(fill), .FILL_ADDR(fad), .SRAM_REQ(sreq), .SRAM_DONE(sdone),
    .SRAM_ERR(serr), .STREAM_PUSH(push), .STREAM_DATA(sdat),
    .STREAM_READY(srdy), .STREAM_ADDR(sad), .STREAM_COUNT(scn), .CACHE_PD(pd),
    .CACHE_EN(en), .IRQ(irq));
  xcc_master m_u (.clk(clk), .stall(stall), .rsp(rsp), .req(req));
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("Error at %0t: timeout", $time);
      summarize;
    end
  end
  function logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic wreg(input logic [7:0] o, input logic [31:0] d);
    @(posedge clk);
    addr <= BASE + o;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] o, input logic [31:0] e);
    @(posedge clk);
    addr <= BASE + o;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 waited = 0;
    while (wt === 1'b1 && waited < 3000) begin
      @(posedge clk);
      #1 waited++;
    end
    check(rdata, e);
  endtask
  // model of tag state and counters decides every expected answer
  task automatic xip(input logic w, input xcc_alias_t a,
      input logic [23:0] x);
    logic m;
    logic h;
    logic al;
    m = tagv.exists(x[13:3]) && tagv[x[13:3]] == x[23:14];
    h = m_en && !w && a <= XCC_ALIAS_CACHE_NOALLOC && m;
    al = m_en && !h && (a == XCC_ALIAS_CACHE_ALLOC ||
                        a == XCC_ALIAS_BYPASS_ALLOC);
    m_u.access(w, a, x, r);
    accs++;
    if (h) hits++;
    if (w && a == XCC_ALIAS_CACHE_ALLOC && m && !m_pd) tagv.delete(x[13:3]);
    check(r.done, 1'b1);
    check(r.hit, h);
    check(r.err, w && a != XCC_ALIAS_CACHE_ALLOC && m_bw);
    if (!w) check(r.to_flash, !h);
    if (!w) check(r.alloc, al);
  endtask
  task automatic fl(input logic [23:0] x);
    @(posedge clk);
    fill <= 1'b1;
    fad <= x;
    @(posedge clk);
    fill <= 1'b0;
    fad <= ~x;
    if (m_en) tagv[x[13:3]] = x[23:14];
  endtask
  task automatic sram(input logic e);
    @(posedge clk);
    sreq <= 1'b1;
    @(posedge clk);
    sreq <= 1'b0;
    #1 check(sdone, 1'b1);
    check(serr, e);
  endtask
  task automatic spush(input logic [31:0] d);
    @(posedge clk);
    push <= 1'b1;
    sdat <= d;
    @(posedge clk);
    push <= 1'b0;
    if (fq.size() < 2) fq.push_back(d);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rchk(8'h08, 32'h2);
    rchk(8'h00, 32'h3);
    rchk(8'h04, 32'h0);
    check(waited > 2000, 1'b1);
    rchk(8'h08, 32'h3);
    $display("test reset flush done");
    v = rnd();
    ad = v[23:0];
    xip(1'b0, XCC_ALIAS_CACHE_ALLOC, ad);
    fl(ad);
    xip(1'b0, XCC_ALIAS_CACHE_ALLOC, ad);
    xip(1'b0, XCC_ALIAS_CACHE_NOALLOC, ad);
    xip(1'b0, XCC_ALIAS_BYPASS, ad);
    xip(1'b0, XCC_ALIAS_BYPASS_ALLOC, ad);
    xip(1'b1, XCC_ALIAS_CACHE_ALLOC, ad);
    xip(1'b0, XCC_ALIAS_CACHE_ALLOC, ad);
    rchk(8'h0C, hits);
    rchk(8'h10, accs);
    wreg(8'h10, rnd());
    accs = 0;
    rchk(8'h10, 32'h0);
    fl(ad);
    wreg(8'h24, 32'h2);
    for (int b = 1; b >= 0; b--) begin
      for (int i = 0; i < 4; i++) xip(1'b1, xcc_alias_t'(i), ad);
      rchk(8'h20, {30'h0, b[0], 1'b1});
      check(irq, b[0]);
      wreg(8'h20, 32'h2);
      wreg(8'h00, 32'h1);
      m_bw = 1'b0;
    end
    $display("test lookup and faults done");
    fl(ad);
    wreg(8'h00, 32'h0);
    m_en = 1'b0;
    xip(1'b0, XCC_ALIAS_CACHE_ALLOC, ad);
    sram(1'b0);
    wreg(8'h00, 32'h1);
    m_en = 1'b1;
    sram(1'b1);
    fl(ad);
    wreg(8'h00, 32'hB);
    m_en = 1'b0;
    m_pd = 1'b1;
    m_bw = 1'b1;
    rchk(8'h00, 32'hA);
    check(pd, 1'b1);
    check(en, 1'b0);
    sram(1'b1);
    xip(1'b1, XCC_ALIAS_CACHE_ALLOC, ad);
    wreg(8'h00, 32'h7);
    m_en = 1'b1;
    m_pd = 1'b0;
    rchk(8'h00, 32'h3);
    xip(1'b0, XCC_ALIAS_CACHE_ALLOC, ad);
    $display("test power and sram done");
    wreg(8'h04, 32'h1);
    tagv.delete();
    #1 check(stall, 1'b1);
    rchk(8'h08, 32'h2);
    xip(1'b0, XCC_ALIAS_CACHE_ALLOC, ad);
    for (int i = 0; i < 3; i++) spush(rnd());
    rchk(8'h08, 32'h5);
    check(srdy, 1'b0);
    repeat (2) rchk(8'h1C, fq.pop_front());
    rchk(8'h08, 32'h3);
    wreg(8'h14, 32'hFFFFFFFF);
    rchk(8'h14, 32'hFFFFFFFC);
    check(sad, 32'h3FFFFFFF);
    v = rnd();
    wreg(8'h18, v);
    rchk(8'h18, {10'h0, v[21:0]});
    check(scn, {10'h0, v[21:0]});
    wreg(8'h28, 32'hFFFFFFFF);
    rchk(8'h28, 32'h0);
    rchk(8'h0C, hits);
    $display("test flush stream map done");
    summarize;
  end
endmodule

// File: test/xcc_chk_assertions.sv
// port checker of the xip cache control
// assumes a bind onto xcc_ctrl and a single clock domain
`timescale 1ns/1ps
module xcc_chk
  import xcc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // register port
  input wire logic REG_WAIT,
  // execute-in-place
  input wire xcc_xip_req_t XIP_REQ,
  input wire logic XIP_STALL,
  input wire xcc_xip_rsp_t XIP_RSP,
  // cache-as-sram and control
  input wire logic SRAM_REQ,
  input wire logic SRAM_DONE,
  input wire logic SRAM_ERR,
  input wire logic CACHE_PD,
  input wire logic CACHE_EN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic [11:0] stall_len;
  logic take;
  assign take = XIP_REQ.valid && !XIP_STALL;
  // a stuck flush engine shows up as an overlong stall
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) stall_len <= 12'h000;
    else stall_len <= XIP_STALL ? stall_len + 12'h001 : 12'h000;
  end
  chk_stall_len: assert property (stall_len <= 12'h802)
    else $error("flush stall too long");
  chk_reset_flush: assert property (!$past(NRST) |-> XIP_STALL)
    else $error("no flush after reset");
  chk_rsp_timing: assert property (take |=> XIP_RSP.done)
    else $error("request not answered");
  chk_stall_hold: assert property (XIP_REQ.valid && XIP_STALL |=>
    !XIP_RSP.done) else $error("request taken during flush");
  chk_off_hit: assert property (take && !CACHE_EN |=> !XIP_RSP.hit)
    else $error("hit while disabled");
  chk_hit_flash: assert property (XIP_RSP.hit |->
    !XIP_RSP.to_flash && !XIP_RSP.err) else $error("hit went to flash");
  chk_pd_en: assert property (CACHE_PD |-> !CACHE_EN)
    else $error("enabled while powered down");
  chk_sram_err: assert property (SRAM_REQ && (CACHE_EN || CACHE_PD)
    |=> SRAM_DONE && SRAM_ERR) else $error("sram access not refused");
  chk_sram_ok: assert property (SRAM_REQ && !CACHE_EN && !CACHE_PD |=>
    SRAM_DONE && !SRAM_ERR) else $error("sram access refused");
  chk_wait_flush: assert property (REG_WAIT |->
    XIP_STALL || $past(XIP_STALL)) else $error("wait without flush");
  chk_read_noerr: assert property (take && !XIP_REQ.write |=>
    !XIP_RSP.err) else $error("read faulted");
  cover property (XIP_RSP.hit);
  cover property (REG_WAIT ##1 !REG_WAIT);
  cover property (SRAM_DONE && SRAM_ERR);
endmodule
bind xcc_ctrl xcc_chk chk_u (.CLK(CLK), .NRST(NRST), .REG_WAIT(REG_WAIT),
  .XIP_REQ(XIP_REQ), .XIP_STALL(XIP_STALL), .XIP_RSP(XIP_RSP),
  .SRAM_REQ(SRAM_REQ), .SRAM_DONE(SRAM_DONE), .SRAM_ERR(SRAM_ERR),
  .CACHE_PD(CACHE_PD), .CACHE_EN(CACHE_EN));

// File: test/xcc_master.sv
// system bus master issuing execute-in-place requests
// assumes one clock; a stalled request is held until taken
`timescale 1ns/1ps
module xcc_master
  import xcc_pkg::*;
(
  // clock
  input wire logic clk,
  // request side
  input wire logic stall,
  input wire xcc_xip_rsp_t rsp,
  output xcc_xip_req_t req
);
  initial req = '0;
  task automatic access(input logic w, input xcc_alias_t a,
      input logic [23:0] x, output xcc_xip_rsp_t r);
    logic took;
    @(posedge clk);
    req <= '{1'b1, w, a, x};
    forever begin
      #1 took = !stall;
      @(posedge clk);
      if (took) break;
    end
    // released lines show inverted write and address bits, not the last request
    req <= '{1'b0, ~w, a, ~x};
    #1 r = rsp;
  endtask
endmodule
